// *** sipo_consts.vh ***
// constants for the serial-in latched power-out shifter
`ifndef SIPO_CONSTS_VH
`define SIPO_CONSTS_VH
`define SIPO_WIDTH 8
`define SIPO_CLEAR_VALUE 8'h00
`define SIPO_SYNC_STAGES 2
`endif

// *** sipo_sync.v ***
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sipo_sync #(
    parameter WIDTH = 5
) (
    // clock and reset
    input wire i_core_clk,
    input wire i_nrst,
    // pins in and synchronised levels out
    input wire [WIDTH-1:0] i_async,
    output reg [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] meta;

    // first stage feeds only the second
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta <= {WIDTH{1'b0}};
            o_sync <= {WIDTH{1'b0}};
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule
`default_nettype wire

// *** sipo_shifter.v ***
// serial-in shift chain, storage latch and open-drain output stage
// Behaviour
// - eight-stage shift chain feeds eight-bit latch
// - shift clock rise shifts; latch clock rise captures
// - clear_n high passes latch to outputs while output enable is low
// - clear_n low zeroes chain, latch, cascade and output buffer
// - output enable high forces all switches off
// - output enable low lets outputs follow latch
// - buffer bit one turns its switch on
// - cascade output changes on shift clock fall
`timescale 1ns/1ps
`default_nettype none
`include "sipo_consts.vh"
module sipo_shifter #(
    parameter WIDTH = `SIPO_WIDTH
) (
    // core clock and reset
    input wire i_core_clk,
    input wire i_nrst,
    // serial control pins from the host
    input wire i_shift_data_input,
    input wire i_shift_clock,
    input wire i_latch_clock,
    input wire i_clear_n,
    input wire i_output_enable_n,
    // cascade output to the next stage
    output reg o_cascade_data_output,
    // open-drain switches: drive low when enabled
    output reg [WIDTH-1:0] o_drain_out,
    output reg [WIDTH-1:0] o_drain_oe
);
    // positions of the pins in the synchroniser bank
    localparam PIN_COUNT = 5;
    localparam PIN_DATA = 0;
    localparam PIN_SHIFT = 1;
    localparam PIN_LATCH = 2;
    localparam PIN_CLEAR = 3;
    localparam PIN_ENABLE = 4;
    // last stage of the chain, seen by the cascade output
    localparam LAST = WIDTH - 1;

    // pin bank before and after synchronisation
    wire [PIN_COUNT-1:0] pins_raw;
    wire [PIN_COUNT-1:0] pins_sync;

    // synchronised pin levels
    wire data_s;
    wire sck_s;
    wire lck_s;
    wire clr_n_s;
    wire oe_n_s;

    // clock edges found by the core clock
    wire shift_rise;
    wire shift_fall;
    wire latch_rise;

    // clock levels one core cycle ago
    reg sck_d;
    reg lck_d;

    // shift chain, storage latch and their next values
    reg [WIDTH-1:0] chain;
    reg [WIDTH-1:0] next_chain;
    reg [WIDTH-1:0] latch;
    reg [WIDTH-1:0] next_latch;

    // cascade and output buffer next values
    reg next_cascade;
    reg [WIDTH-1:0] next_buf;

    // rising edge: high now, low one core cycle ago
    function rise_seen;
        input now_level;
        input last_level;
        begin
            rise_seen = now_level & ~last_level;
        end
    endfunction

    // falling edge: low now, high one core cycle ago
    function fall_seen;
        input now_level;
        input last_level;
        begin
            fall_seen = ~now_level & last_level;
        end
    endfunction

    // one shift step: serial bit enters at bit zero, the top bit drops out
    function [WIDTH-1:0] shift_once;
        input [WIDTH-1:0] old_chain;
        input serial_bit;
        begin
            shift_once = {old_chain[WIDTH-2:0], serial_bit};
        end
    endfunction

    // pins cross into the core clock through two flops
    // limitation: pin pulses shorter than one core cycle can be missed
    assign pins_raw = {i_output_enable_n, i_clear_n, i_latch_clock, i_shift_clock, i_shift_data_input};
    sipo_sync #(
        .WIDTH(PIN_COUNT)
    ) sipo_sync_i (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_async(pins_raw),
        .o_sync(pins_sync)
    );

    assign data_s = pins_sync[PIN_DATA];
    assign sck_s = pins_sync[PIN_SHIFT];
    assign lck_s = pins_sync[PIN_LATCH];
    assign clr_n_s = pins_sync[PIN_CLEAR];
    assign oe_n_s = pins_sync[PIN_ENABLE];

    // reset to the idle low level so that no false edge follows reset
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sck_d <= 1'b0;
        end else begin
            sck_d <= sck_s;
        end
    end

    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            lck_d <= 1'b0;
        end else begin
            lck_d <= lck_s;
        end
    end

    // data comes from the same sample as the edge, so pin setup is kept inside the core
    assign shift_rise = rise_seen(sck_s, sck_d);
    assign shift_fall = fall_seen(sck_s, sck_d);
    assign latch_rise = rise_seen(lck_s, lck_d);

    // while clear is low both clocks are ignored
    always @* begin
        next_chain = chain;
        if (!clr_n_s) begin
            next_chain = `SIPO_CLEAR_VALUE;
        end else if (shift_rise) begin
            next_chain = shift_once(chain, data_s);
        end
    end

    // a latch rise with a coincident shift takes the chain before the shift
    always @* begin
        next_latch = latch;
        if (!clr_n_s) begin
            next_latch = `SIPO_CLEAR_VALUE;
        end else if (latch_rise) begin
            next_latch = chain;
        end
    end

    // cascade waits for the fall to give the next stage half a period of hold
    always @* begin
        next_cascade = o_cascade_data_output;
        if (!clr_n_s) begin
            next_cascade = 1'b0;
        end else if (shift_fall) begin
            next_cascade = chain[LAST];
        end
    end

    // output buffer: clear and enable gate the latch
    always @* begin
        if (!clr_n_s || oe_n_s) begin
            next_buf = {WIDTH{1'b0}};
        end else begin
            next_buf = latch;
        end
    end

    // shift chain register
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            chain <= `SIPO_CLEAR_VALUE;
        end else begin
            chain <= next_chain;
        end
    end

    // storage latch register
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            latch <= `SIPO_CLEAR_VALUE;
        end else begin
            latch <= next_latch;
        end
    end

    // cascade flop
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_cascade_data_output <= 1'b0;
        end else begin
            o_cascade_data_output <= next_cascade;
        end
    end

    // open drain: the pin level is only ever pulled low
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_drain_out <= {WIDTH{1'b0}};
        end else begin
            o_drain_out <= {WIDTH{1'b0}};
        end
    end

    // a one in the buffer pulls the drain low; a zero releases it
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_drain_oe <= {WIDTH{1'b0}};
        end else begin
            o_drain_oe <= next_buf;
        end
    end
endmodule
`default_nettype wire

// *** sipo_host.sv ***
// host model driving the serial control pins
`timescale 1ns/1ps
`default_nettype none
module sipo_host (
    // core clock that paces the pins
    input wire logic clk,
    // cascade output, read back before every shift rise
    input wire logic i_cas,
    // serial control pins
    output var logic o_sck,
    output var logic o_lck,
    output var logic o_sdi
);
    // cascade bits seen before each rise, oldest in the top bit
    logic [7:0] seen;

    initial begin
        o_sck = 1'b0;
        o_lck = 1'b0;
        o_sdi = 1'b0;
        seen = 8'h00;
    end

    // wait n core edges, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one byte msb first, 320 ns per bit; data stands 2 cycles before and 6 after each rise
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            o_sdi = b[i];
            tick(2);
            seen = {seen[6:0], i_cas};
            o_sck = 1'b1;
            tick(4);
            o_sck = 1'b0;
            tick(2);
        end
    endtask

    // one latch pulse after the last shift of a frame
    task automatic pulse();
        tick(1);
        o_lck = 1'b1;
        tick(4);
        o_lck = 1'b0;
        tick(8);
    endtask
endmodule
`default_nettype wire

// *** sipo_shifter_monitor.sv ***
// checker for the shifter outputs, bound into the shifter
`timescale 1ns/1ps
`default_nettype none
module sipo_mon (
    // core clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // control pins as the host and bench drive them
    input wire logic i_shift_clock,
    input wire logic i_latch_clock,
    input wire logic i_clear_n,
    input wire logic i_output_enable_n,
    // shifter outputs
    input wire logic o_cascade_data_output,
    input wire logic [7:0] o_drain_out,
    input wire logic [7:0] o_drain_oe
);
    wire g = i_output_enable_n;
    wire c = i_clear_n;
    wire s = o_cascade_data_output;
    wire [7:0] q = o_drain_oe;

    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);

    AST_OD: assert property (o_drain_out == 8'h00) else $error("drain driven high");
    AST_GO: assert property (g [*6] |-> q == 8'h00) else $error("switch on while disabled");
    AST_GR: assert property ($rose(g) |-> ##[1:5] q == 8'h00) else $error("disable too slow");
    AST_CL: assert property ((!c) [*6] |-> q == 8'h00 && !s) else $error("clear not held");
    AST_CF: assert property ($fell(c) |-> ##[1:6] q == 8'h00) else $error("clear too slow");
    AST_SC: assert property ((i_shift_clock && c) [*3] |-> $stable(s)) else $error("cascade moved");
    AST_HD: assert property ((!i_latch_clock && c && !g) [*7] |-> $stable(q)) else $error("unlatched move");
    AST_ON: assert property (($past(g, 3) || !$past(c, 3)) |-> q == 8'h00) else $error("gated switch on");
endmodule
bind sipo_shifter sipo_mon sipo_mon_i (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_shift_clock(i_shift_clock),
    .i_latch_clock(i_latch_clock),
    .i_clear_n(i_clear_n),
    .i_output_enable_n(i_output_enable_n),
    .o_cascade_data_output(o_cascade_data_output),
    .o_drain_out(o_drain_out),
    .o_drain_oe(o_drain_oe)
);
`default_nettype wire

// *** sipo_shifter_bench.sv ***
// bench for the serial-in latched power-out shifter
`timescale 1ns/1ps
`default_nettype none
module sipo_shifter_bench;
    // the run needs about 200 core cycles
    localparam int TIME_LIMIT = 1000;

    logic clk;
    logic rn;
    logic clr;
    logic oen;
    wire sck;
    wire lck;
    wire sdi;
    wire cas;
    wire [7:0] dro;
    wire [7:0] doe;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;

    // 25 MHz core clock
    always #20 clk = ~clk;

    // a hang counts as a mismatch and goes to the report
    always @(posedge clk) begin
        cycles++;
        if (cycles >= TIME_LIMIT) begin
            num_errors++;
            tally_and_finish();
        end
    end

    sipo_host sipo_host_i (
        .clk(clk),
        .i_cas(cas),
        .o_sck(sck),
        .o_lck(lck),
        .o_sdi(sdi)
    );

    sipo_shifter sipo_shifter_i (
        .i_core_clk(clk),
        .i_nrst(rn),
        .i_shift_data_input(sdi),
        .i_shift_clock(sck),
        .i_latch_clock(lck),
        .i_clear_n(clr),
        .i_output_enable_n(oen),
        .o_cascade_data_output(cas),
        .o_drain_out(dro),
        .o_drain_oe(doe)
    );

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] expected);
        n_checks++;
        if (seen !== expected) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, expected, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // one frame: the bits read back are the old chain, then cascade shows the first bit sent
    task automatic load_byte(input logic [7:0] b, input logic [7:0] old_chain);
        sipo_host_i.send(b);
        chk("cascade_read_back", sipo_host_i.seen, old_chain);
        sipo_host_i.tick(2);
        chk("cascade_last", {7'h00, cas}, {7'h00, b[7]});
    endtask

    // load and latch, then disable and re-enable the switches
    task automatic t_load();
        oen = 1'b0;
        load_byte(8'hA5, 8'h00);
        sipo_host_i.pulse();
        chk("switches_on", doe, 8'hA5);
        chk("drain_level", dro, 8'h00);
        oen = 1'b1;
        sipo_host_i.tick(6);
        chk("switches_disabled", doe, 8'h00);
        oen = 1'b0;
        sipo_host_i.tick(6);
        chk("switches_back", doe, 8'hA5);
    endtask

    // a new frame without a latch pulse leaves the switches; clear empties everything
    task automatic t_clear();
        load_byte(8'hC3, 8'hA5);
        chk("latch_held", doe, 8'hA5);
        clr = 1'b0;
        sipo_host_i.tick(6);
        chk("clear_switches", doe, 8'h00);
        chk("clear_cascade", {7'h00, cas}, 8'h00);
        clr = 1'b1;
        sipo_host_i.tick(4);
        sipo_host_i.pulse();
        chk("clear_chain", doe, 8'h00);
    endtask

    initial begin
        clk = 1'b0;
        rn = 1'b0;
        clr = 1'b1;
        oen = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        rn = 1'b1;
        sipo_host_i.tick(4);
        t_load();
        t_clear();
        tally_and_finish();
    end
endmodule
`default_nettype wire
